// ---- utd_pkg.sv ----
// Shared constants and types for the transmit DMA request block
package utd_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_TX_HOLD = 8'h00;  // Transmit data into the queue
  localparam logic [7:0] OFS_EFR_QCR = 8'h08;  // Shared: enhanced feature / queue control
  localparam logic [7:0] OFS_LCR = 8'h0c;      // Line control and portal selector
  localparam logic [7:0] OFS_MCR = 8'h10;      // Modem control
  localparam logic [7:0] OFS_STATUS = 8'h14;   // Queue status, read only
  localparam logic [7:0] OFS_TLR = 8'h1c;      // Shared: scratch / trigger level
  localparam logic [7:0] OFS_SCR = 8'h40;      // Supplementary control
  localparam logic [7:0] OFS_MODE_DEFINITION_THREE = 8'h80;     // Mode definition three
  localparam logic [7:0] OFS_TX_DMA_THRESHOLD_LEVEL = 8'h84;    // Transmit DMA threshold

  // ==========================================================
  // Portal keys and field positions
  localparam logic [7:0] LCR_KEY_EFR = 8'hbf;  // Opens the enhanced feature register
  localparam logic [7:0] LCR_KEY_QCR = 8'h00;  // Restores queue control access
  localparam int EFR_EXT_EN_BIT = 4;           // Extended function enable
  localparam int SCR_UNIT_GRAN_BIT = 6;        // Unit step transmit granularity
  localparam int MCR_TLR_EN_BIT = 6;           // Exposes the trigger level register
  localparam int MODE_DEFINITION_THREE_THR_EN_BIT = 2;          // Use the DMA threshold register

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;     // All control bytes clear at reset
  localparam logic [5:0] RST_TX_DMA_THRESHOLD_LEVEL = 6'h00;    // Threshold clear at reset

  // ==========================================================
  // Queue geometry
  localparam int DEPTH = 64;                   // Transmit queue capacity
  localparam logic [6:0] DEPTH_CNT = 7'h40;    // Capacity as a count
  localparam logic [5:0] LVL_ONE = 6'h01;      // Smallest trigger level

  // Coarse trigger steps selected by queue control bits 5:4
  localparam logic [5:0] STEP_0 = 6'h08;
  localparam logic [5:0] STEP_1 = 6'h10;
  localparam logic [5:0] STEP_2 = 6'h20;
  localparam logic [5:0] STEP_3 = 6'h38;

  // Trigger configuration that travels together
  typedef struct packed {
    logic unit_gran;                           // One-entry granularity
    logic [3:0] tlr_bits;                      // Trigger level register bits 3:0
    logic [1:0] qcr_bits;                      // Queue control bits 5:4
  } utd_trig_cfg_t;

endpackage

// ---- utd_tx_dma.sv ----
// Transmit queue, overlaid register file and DMA request generation
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// Function
// - Full flag when queue holds 64 entries
// - Request made in bus clock domain
// - Line control BFh opens enhanced feature register
// - Extended enable bit permits modem control writes
// - Line control 00h restores queue control access
// - Supplementary bit 6 selects one-entry granularity
// - Modem control bit 6 exposes trigger level
// - Level from trigger bits and queue bits
// - Mode three bit 2 enables DMA threshold
// - Six-bit DMA threshold register
// - Line control selects enhanced feature or queue control overlay; modem control bit 6 selects trigger level or scratch
module utd_tx_dma (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic o_fifo_full,
  output logic o_serial_transmit_request_line
);

  // ==========================================================
  // Register storage
  logic [7:0] lcr_ff;          // Portal selector
  logic [7:0] efr_ff;          // Enhanced feature control
  logic [7:0] qcr_ff;          // Queue control
  logic [7:0] mcr_ff;          // Modem control
  logic [7:0] tlr_ff;          // Trigger level
  logic [7:0] spr_ff;          // Scratch, shares the trigger offset
  logic [7:0] scr_ff;          // Supplementary control
  logic [7:0] mode_definition_three_ff;         // Mode definition three
  logic [5:0] tx_dma_threshold_level_ff;        // DMA threshold
  logic [31:0] prdata_ff;      // Read data, captured in setup
  logic pslverr_ff;            // Error, captured in setup

  // Bus phase decode
  logic wr_acc;
  logic setup;
  logic efr_open;
  logic tlr_open;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign setup = i_psel && !i_penable;
  assign efr_open = (lcr_ff == utd_pkg::LCR_KEY_EFR);
  assign tlr_open = mcr_ff[utd_pkg::MCR_TLR_EN_BIT] && efr_ff[utd_pkg::EFR_EXT_EN_BIT];

  // ==========================================================
  // Register writes; each takes effect at the access edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      lcr_ff <= utd_pkg::RST_BYTE;
      efr_ff <= utd_pkg::RST_BYTE;
      qcr_ff <= utd_pkg::RST_BYTE;
      mcr_ff <= utd_pkg::RST_BYTE;
      tlr_ff <= utd_pkg::RST_BYTE;
      spr_ff <= utd_pkg::RST_BYTE;
      scr_ff <= utd_pkg::RST_BYTE;
      mode_definition_three_ff <= utd_pkg::RST_BYTE;
      tx_dma_threshold_level_ff <= utd_pkg::RST_TX_DMA_THRESHOLD_LEVEL;
    end
    else if (wr_acc)
    begin
      // Selector value decides which overlay answers
      if (i_paddr == utd_pkg::OFS_LCR)
        lcr_ff <= i_pwdata[7:0];
      else if (i_paddr == utd_pkg::OFS_EFR_QCR)
      begin
        if (efr_open)
          efr_ff <= i_pwdata[7:0];
        else
          qcr_ff <= i_pwdata[7:0];
      end
      else if (i_paddr == utd_pkg::OFS_MCR)
      begin
        // Locked until the extended enable is set
        if (efr_ff[utd_pkg::EFR_EXT_EN_BIT])
          mcr_ff <= i_pwdata[7:0];
      end
      else if (i_paddr == utd_pkg::OFS_TLR)
      begin
        if (tlr_open)
          tlr_ff <= i_pwdata[7:0];
        else
          spr_ff <= i_pwdata[7:0];
      end
      else if (i_paddr == utd_pkg::OFS_SCR)
        scr_ff <= i_pwdata[7:0];
      else if (i_paddr == utd_pkg::OFS_MODE_DEFINITION_THREE)
        mode_definition_three_ff <= i_pwdata[7:0];
      else if (i_paddr == utd_pkg::OFS_TX_DMA_THRESHOLD_LEVEL)
        tx_dma_threshold_level_ff <= i_pwdata[5:0];
    end
  end

  // ==========================================================
  // Transmit queue, 64 bytes of flops
  logic [7:0] mem [utd_pkg::DEPTH];
  logic [5:0] wptr_ff;
  logic [5:0] rptr_ff;
  logic [6:0] count_ff;
  logic push;
  logic pop;
  logic buf_in_ready;
  // A write while full is dropped; software must respect the threshold
  assign push = wr_acc && (i_paddr == utd_pkg::OFS_TX_HOLD) && !o_fifo_full;
  assign pop = (count_ff != 7'h00) && buf_in_ready;
  assign o_fifo_full = (count_ff == utd_pkg::DEPTH_CNT);

  // Per-entry storage write
  genvar gi;
  generate
    for (gi = 0; gi < utd_pkg::DEPTH; gi++)
    begin : g_ent
      always_ff @(posedge i_clk)
      begin
        if (push && (wptr_ff == 6'(gi)))
          mem[gi] <= i_pwdata[7:0];
      end
    end
  endgenerate

  // Pointers and occupancy
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wptr_ff <= 6'h00;
      rptr_ff <= 6'h00;
      count_ff <= 7'h00;
    end
    else
    begin
      if (push)
        wptr_ff <= wptr_ff + 6'h01;
      if (pop)
        rptr_ff <= rptr_ff + 6'h01;
      if (push && !pop)
        count_ff <= count_ff + 7'h01;
      else if (pop && !push)
        count_ff <= count_ff - 7'h01;
    end
  end

  // ==========================================================
  // Two-entry output buffer; a stalled receiver loses no byte
  logic [7:0] slot_ff [2];
  logic [1:0] bcnt_ff;
  logic bpop;
  assign buf_in_ready = (bcnt_ff != 2'h2);
  assign bpop = o_tx_valid && i_tx_ready;
  assign o_tx_valid = (bcnt_ff != 2'h0);
  assign o_tx_data = slot_ff[0];

  // Shift on drain, fill at the tail
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bcnt_ff <= 2'h0;
      slot_ff[0] <= 8'h00;
      slot_ff[1] <= 8'h00;
    end
    else
    begin
      case ({pop, bpop})
        2'b10:
        begin
          slot_ff[bcnt_ff[0]] <= mem[rptr_ff];
          bcnt_ff <= bcnt_ff + 2'h1;
        end
        2'b01:
        begin
          slot_ff[0] <= slot_ff[1];
          bcnt_ff <= bcnt_ff - 2'h1;
        end
        2'b11:
        begin
          // Count stays; with one held the new byte becomes head
          if (bcnt_ff == 2'h1)
            slot_ff[0] <= mem[rptr_ff];
          else
          begin
            slot_ff[0] <= slot_ff[1];
            slot_ff[1] <= mem[rptr_ff];
          end
        end
        default:
        begin
          bcnt_ff <= bcnt_ff;
        end
      endcase
    end
  end

  // ==========================================================
  // Trigger level
  utd_pkg::utd_trig_cfg_t trig_cfg;
  logic [5:0] raw_lvl;
  logic [5:0] trig_lvl;
  assign trig_cfg = '{unit_gran: scr_ff[utd_pkg::SCR_UNIT_GRAN_BIT],
                      tlr_bits: tlr_ff[3:0], qcr_bits: qcr_ff[5:4]};
  assign raw_lvl = {trig_cfg.tlr_bits, trig_cfg.qcr_bits};

  // Unit step uses all six bits, coarse step keeps table or nibble
  always_comb
  begin
    if (trig_cfg.unit_gran)
      trig_lvl = (raw_lvl < 6'h02) ? utd_pkg::LVL_ONE : raw_lvl;
    else if (trig_cfg.tlr_bits != 4'h0)
      trig_lvl = {trig_cfg.tlr_bits, 2'b00};
    else
    begin
      case (trig_cfg.qcr_bits)
        2'b00: trig_lvl = utd_pkg::STEP_0;
        2'b01: trig_lvl = utd_pkg::STEP_1;
        2'b10: trig_lvl = utd_pkg::STEP_2;
        default: trig_lvl = utd_pkg::STEP_3;
      endcase
    end
  end

  // ==========================================================
  // Full flag into the request logic through two flops
  logic full_meta_ff;
  logic full_sync_ff;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      full_meta_ff <= 1'b0;
      full_sync_ff <= 1'b0;
    end
    else
    begin
      full_meta_ff <= o_fifo_full;
      full_sync_ff <= full_meta_ff;
    end
  end

  // ==========================================================
  // Request: one pulse per rising request condition
  logic [5:0] thr;
  logic [6:0] free_cnt;
  logic req_cond;
  logic cond_q_ff;
  logic req_ff;
  assign thr = mode_definition_three_ff[utd_pkg::MODE_DEFINITION_THREE_THR_EN_BIT] ? tx_dma_threshold_level_ff : trig_lvl;
  assign free_cnt = utd_pkg::DEPTH_CNT - count_ff;
  // Held off while full so a late full edge adds no pulse
  assign req_cond = (free_cnt >= {1'b0, thr}) && !full_sync_ff;
  assign o_serial_transmit_request_line = req_ff;

  // Pulse made in the bus clock domain
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cond_q_ff <= 1'b0;
      req_ff <= 1'b0;
    end
    else
    begin
      cond_q_ff <= req_cond;
      req_ff <= req_cond && !cond_q_ff;
    end
  end

  // ==========================================================
  // Read path, captured in the setup cycle; zero wait access
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (i_paddr == utd_pkg::OFS_TX_HOLD)
        prdata_ff <= 32'h0000_0000;
      else if (i_paddr == utd_pkg::OFS_EFR_QCR)
        prdata_ff <= {24'h000000, efr_open ? efr_ff : qcr_ff};
      else if (i_paddr == utd_pkg::OFS_LCR)
        prdata_ff <= {24'h000000, lcr_ff};
      else if (i_paddr == utd_pkg::OFS_MCR)
        prdata_ff <= {24'h000000, mcr_ff};
      else if (i_paddr == utd_pkg::OFS_STATUS)
        prdata_ff <= {17'h00000, count_ff, 6'h00, full_sync_ff, o_fifo_full};
      else if (i_paddr == utd_pkg::OFS_TLR)
        prdata_ff <= {24'h000000, tlr_open ? tlr_ff : spr_ff};
      else if (i_paddr == utd_pkg::OFS_SCR)
        prdata_ff <= {24'h000000, scr_ff};
      else if (i_paddr == utd_pkg::OFS_MODE_DEFINITION_THREE)
        prdata_ff <= {24'h000000, mode_definition_three_ff};
      else if (i_paddr == utd_pkg::OFS_TX_DMA_THRESHOLD_LEVEL)
        prdata_ff <= {26'h0000000, tx_dma_threshold_level_ff};
      else
        pslverr_ff <= 1'b1;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = i_psel && i_penable;
  assign o_pslverr = pslverr_ff && i_psel && i_penable;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_full_at_capacity: assert property (count_ff == 7'h40 |-> o_fifo_full && !push)
    else $error("full flag missing at capacity");
  a_req_one_pulse: assert property (req_ff |=> !req_ff)
    else $error("request wider than one cycle");
  a_efr_via_key: assert property (wr_acc && i_paddr == 8'h08 && lcr_ff == 8'hbf
      |=> efr_ff == $past(i_pwdata[7:0]))
    else $error("enhanced register not written through key");
  a_mcr_write_lock: assert property (wr_acc && i_paddr == 8'h10 && !efr_ff[4]
      |=> $stable(mcr_ff))
    else $error("modem control written while locked");
  a_qcr_restored: assert property (wr_acc && i_paddr == 8'h08 && lcr_ff == 8'h00
      |=> qcr_ff == $past(i_pwdata[7:0]) && $stable(efr_ff))
    else $error("queue control not restored");
  a_unit_level_one: assert property (scr_ff[6] && tlr_ff[3:0] == 4'h0 && !qcr_ff[5]
      |-> trig_lvl == 6'h01)
    else $error("unit granularity level not one");
  a_tlr_exposed: assert property (wr_acc && i_paddr == 8'h1c && mcr_ff[6] && efr_ff[4]
      |=> tlr_ff == $past(i_pwdata[7:0]) && $stable(spr_ff))
    else $error("trigger level not exposed");
  a_unit_level_bits: assert property (scr_ff[6] && raw_lvl > 6'h01
      |-> trig_lvl == {tlr_ff[3:0], qcr_ff[5:4]})
    else $error("trigger level bits wrong");
  a_thr_selected: assert property (mode_definition_three_ff[2] |-> thr == tx_dma_threshold_level_ff)
    else $error("DMA threshold not used");
  a_tx_dma_threshold_level_six_bits: assert property (wr_acc && i_paddr == 8'h84
      |=> tx_dma_threshold_level_ff == $past(i_pwdata[5:0]))
    else $error("threshold register not written");
  a_portal_read: assert property (setup && i_paddr == 8'h08 && lcr_ff == 8'hbf
      |=> o_prdata == {24'h000000, $past(efr_ff)})
    else $error("portal read wrong overlay");
  a_full_two_flops: assert property ($rose(full_sync_ff) |-> $past(o_fifo_full, 2))
    else $error("full flag not synchronised");
  a_req_on_space: assert property (req_cond && !cond_q_ff |=> req_ff ##1 !req_ff)
    else $error("request missing on threshold");

endmodule

// ---- utd_dma_model.sv ----
// Behavioural DMA-side partner: counts requests and sinks the byte stream
`timescale 1ns/1ps

module utd_dma_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_stall,
  output logic o_ready,
  output int o_pulses,
  output int o_rx,
  output int o_bad
);
  // Ready is a level; the bench stalls us to back the stream up
  assign o_ready = !i_stall;

  // ==========================================================
  // Request and stream bookkeeping
  // Request sampled on the bus clock, one count per high cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pulses <= 0;
      o_rx <= 0;
      o_bad <= 0;
    end
    else
    begin
      if (i_req === 1'b1)
        o_pulses <= o_pulses + 1;
      // Bytes must arrive in the order they were written
      if (i_valid === 1'b1 && o_ready)
      begin
        o_rx <= o_rx + 1;
        if (i_data !== o_rx[7:0])
          o_bad <= o_bad + 1;
      end
    end
  end
endmodule

// ---- tb_uart_tx_dma_request_threshold.sv ----
// Self-checking bench for the transmit DMA request block
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module tb_uart_tx_dma_request_threshold;
  // ==========================================================
  // Signals
  logic i_clk, i_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, tx_data, seq; // Seq is the next stream byte
  logic [31:0] pwdata, prdata;
  logic tx_valid, tx_ready, full, req, stall;
  int pulses, rx, bad, failures, tests_run;

  utd_tx_dma i_dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .o_tx_data(tx_data),
    .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready),
    .o_fifo_full(full),
    .o_serial_transmit_request_line(req)
  );

  utd_dma_model i_dma (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(req),
    .i_data(tx_data),
    .i_valid(tx_valid),
    .i_stall(stall),
    .o_ready(tx_ready),
    .o_pulses(pulses),
    .o_rx(rx),
    .o_bad(bad)
  );

  // ==========================================================
  // Bus tasks
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q)
  endtask

  // Sequential bytes so the partner can check order
  task automatic push(input int n);
    repeat (n)
    begin
      wr(utd_pkg::OFS_TX_HOLD, {24'h0, seq});
      seq = seq + 8'h01;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] regs [5] = '{utd_pkg::OFS_LCR, utd_pkg::OFS_MCR, utd_pkg::OFS_SCR,
                            utd_pkg::OFS_MODE_DEFINITION_THREE, utd_pkg::OFS_TX_DMA_THRESHOLD_LEVEL};
    foreach (regs[i])
      rdchk(regs[i], 32'h0, "reset value");
    `CHK("pulses after reset", 1, pulses)
  endtask

  // Overlay walk in the documented order, ending with threshold 62 plus level 1
  task automatic t_portal();
    logic [31:0] q;
    logic e;
    wr(utd_pkg::OFS_LCR, 32'hbf);
    wr(utd_pkg::OFS_MCR, 32'h40);
    rdchk(utd_pkg::OFS_MCR, 32'h0, "locked modem ctrl");
    wr(utd_pkg::OFS_EFR_QCR, 32'h10);
    rdchk(utd_pkg::OFS_EFR_QCR, 32'h10, "enhanced feature");
    wr(utd_pkg::OFS_LCR, 32'h00);
    rdchk(utd_pkg::OFS_EFR_QCR, 32'h0, "queue ctrl view");
    wr(utd_pkg::OFS_SCR, 32'h40);
    rdchk(utd_pkg::OFS_SCR, 32'h40, "supplementary");
    wr(utd_pkg::OFS_TLR, 32'h05);
    wr(utd_pkg::OFS_MCR, 32'h40);
    rdchk(utd_pkg::OFS_MCR, 32'h40, "modem ctrl");
    rdchk(utd_pkg::OFS_TLR, 32'h0, "trigger view");
    wr(utd_pkg::OFS_EFR_QCR, 32'h10);
    rdchk(utd_pkg::OFS_EFR_QCR, 32'h10, "queue ctrl");
    wr(utd_pkg::OFS_MODE_DEFINITION_THREE, 32'h04);
    rdchk(utd_pkg::OFS_MODE_DEFINITION_THREE, 32'h04, "mode three");
    wr(utd_pkg::OFS_TX_DMA_THRESHOLD_LEVEL, 32'h3e);
    rdchk(utd_pkg::OFS_TX_DMA_THRESHOLD_LEVEL, 32'h3e, "dma threshold");
    apb(1'b0, 8'h30, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
  endtask

  // Fill to capacity with the sink stalled, then drain; DMA threshold 62 in force
  task automatic t_full();
    int p;
    p = pulses;
    stall <= 1'b1;
    push(65);
    repeat (3) @(posedge i_clk);
    `CHK("full at 63", 1'b0, full)
    push(1);
    repeat (3) @(posedge i_clk);
    `CHK("full at 64", 1'b1, full)
    wr(utd_pkg::OFS_TX_HOLD, {24'h0, seq});
    rdchk(utd_pkg::OFS_STATUS, 32'h0000_4003, "status when full");
    stall <= 1'b0;
    repeat (150) @(posedge i_clk);
    `CHK("full after drain", 1'b0, full)
    `CHK("pulses after drain", p + 1, pulses)
  endtask

  // Threshold 62: two queued bytes keep the condition, three drop it
  task automatic t_thresh();
    int p;
    for (int n = 4; n <= 5; n++)
    begin
      p = pulses;
      stall <= 1'b1;
      push(n);
      repeat (4) @(posedge i_clk);
      stall <= 1'b0;
      repeat (20) @(posedge i_clk);
      `CHK("threshold pulses", p + n - 4, pulses)
    end
    `CHK("bytes delivered", 75, rx)
    `CHK("order faults", 0, bad)
  endtask

  // ==========================================================
  // Verdict, clock, watchdog and main sequence
  task automatic conclude();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Whole run needs about 520 cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    conclude();
  end

  initial
  begin
    {i_rst, psel, penable, pwrite, stall} = 5'b10000;
    {paddr, pwdata, seq} = '0;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_portal();
    t_full();
    t_thresh();
    conclude();
  end
endmodule
